// [rtl/ocd_map.vh]
// opcode encodings, cycle figures and timing constants for the decoder
`ifndef OCD_MAP_VH
`define OCD_MAP_VH
// ---------------------------------------------------------------
// opcode bytes
// ---------------------------------------------------------------
`define OCD_ESC 8'h0f
`define OCD_MOV_TO_SEG 8'h8e
`define OCD_MOV_FROM_SEG 8'h8c
`define OCD_MOV_RM_W 7'h44
`define OCD_MOV_R_RM 7'h45
`define OCD_MOV_IMM_RM 7'h63
`define OCD_MOV_M2A 7'h50
`define OCD_MOV_A2M 7'h51
`define OCD_MOV_IMM_R 4'hb
`define OCD_SWAP_ACC 5'h12
`define OCD_SWAP_RM 7'h43
`define OCD_EA_LOAD 8'h8d
`define OCD_FAR_DSEG 8'hc5
`define OCD_FAR_ESEG 8'hc4
`define OCD_CARRY_CLR 8'hf8
`define OCD_CARRY_SET 8'hf9
`define OCD_CARRY_INV 8'hf5
`define OCD_DIR_CLR 8'hfc
`define OCD_DIR_SET 8'hfd
`define OCD_INT_CLR 8'hfa
`define OCD_INT_SET 8'hfb
`define OCD_ACCH_TO_FL 8'h9e
`define OCD_FL_TO_ACCH 8'h9f
// second bytes after the escape byte
`define OCD_X_SIGN_EXT 7'h5f
`define OCD_X_ZERO_EXT 7'h5b
`define OCD_X_FAR_FSEG 8'hb4
`define OCD_X_FAR_GSEG 8'hb5
`define OCD_X_FAR_STACK 8'hb2
`define OCD_X_TS_CLR 8'h06
// segment push/pop low three bits
`define OCD_SEG_PUSH_LO 3'h6
`define OCD_SEG_POP_LO 3'h7
// ---------------------------------------------------------------
// cycle figures (processor cycles)
// ---------------------------------------------------------------
`define OCD_CY_2 8'h02
`define OCD_CY_3 8'h03
`define OCD_CY_4 8'h04
`define OCD_CY_5 8'h05
`define OCD_CY_6 8'h06
`define OCD_CY_7 8'h07
`define OCD_CY_8 8'h08
`define OCD_CY_18 8'h12
`define OCD_CY_19 8'h13
`define OCD_CY_21 8'h15
`define OCD_CY_22 8'h16
`define OCD_CY_25 8'h19
`define OCD_EA_EXTRA 8'h01
`define OCD_WAIT_EXTRA 8'h01
// processor clock is double-rate input divided by this
`define OCD_CLK_DIV 2
`endif

// [rtl/ocd_clk_half.v]
// divide-by-two processor cycle strobe from the double-rate clock input
`timescale 1ns/1ps
module ocd_clk_half
(
    input wire clk_sys,
    input wire srst,
    input wire double_rate_clock_in,
    output reg proc_cycle_r
);
// ---------------------------------------------------------------
// sync, edge detect, divide
// ---------------------------------------------------------------
reg sync1_r;
reg sync2_r;
reg prev_r;
reg phase_r;
wire rise = sync2_r & ~prev_r;
always @(posedge clk_sys)
begin
    if (srst)
    begin
        sync1_r <= 1'b0;
        sync2_r <= 1'b0;
        prev_r <= 1'b0;
        phase_r <= 1'b0;
        proc_cycle_r <= 1'b0;
    end
    else
    begin
        sync1_r <= double_rate_clock_in;
        sync2_r <= sync1_r;
        prev_r <= sync2_r;
        if (rise)
            phase_r <= ~phase_r;
        proc_cycle_r <= rise & phase_r;
    end
end
endmodule // ocd_clk_half

// [rtl/ocd_adjust.v]
// adds address-form and wait-state extras to a base cycle count
`timescale 1ns/1ps
`include "ocd_map.vh"
module ocd_adjust
#(
    parameter CW = 8
)
(
    input wire [CW-1:0] base_cycles,
    input wire ea_two_regs,
    input wire uses_mem,
    input wire [3:0] wait_states,
    input wire [2:0] data_accesses,
    output wire [CW-1:0] total_cycles
);
// ---------------------------------------------------------------
// extras
// ---------------------------------------------------------------
wire [CW-1:0] ea_add;
wire [CW-1:0] wait_add;
// full 7-bit product, fifteen waits times seven accesses
wire [6:0] wait_prod;
assign ea_add = (uses_mem & ea_two_regs) ? `OCD_EA_EXTRA : {CW{1'b0}};
assign wait_prod = wait_states * data_accesses;
assign wait_add = {{(CW-7){1'b0}}, wait_prod};
assign total_cycles = base_cycles + ea_add + wait_add;
endmodule // ocd_adjust

// [rtl/ocd_decode.v]
// opcode decoder with execution cycle accounting
// Overview of operation
// - two-register address adds one cycle
// - one cycle per wait state per access
// - register operand smaller, memory operand larger
// - base counts assume ideal prefetched execution
// - displacement and immediate each one component
// - processor cycle is half input clock
// - move to segment: 2/5, 18/19
// - memory-accumulator moves: 4 and 2
// - immediate to register short: 2
// - sign extending move: 3/6
// - zero extending move: 3/6
// - segment pop: 7 real, 21 protected
// - segment push: 2 cycles
// - swap with accumulator: 3 cycles
// - effective address load: 2 cycles
// - far pointer data/extra/stack: 7, 22
// - far pointer extra segments: 7, 25
// - carry clear/set/invert: 2 cycles
// - direction clear/set: 2 cycles
// - interrupt-enable clear/set: 8, privilege checked
// - task-switched clear: 6 cycles
// - flags/high accumulator transfers: 3 and 2
`timescale 1ns/1ps
`include "ocd_map.vh"
module ocd_decode
#(
    parameter CW = 8
)
(
    input wire clk_sys,
    input wire srst,
    input wire double_rate_clock_in,
    input wire instr_valid,
    input wire [7:0] op_byte0,
    input wire [7:0] op_byte1,
    input wire [7:0] op_byte2,
    input wire protected_mode,
    input wire io_priv_ok,
    input wire ea_two_regs,
    input wire [3:0] wait_states,
    input wire [2:0] data_accesses,
    input wire [2:0] next_disp_present,
    input wire next_imm_present,
    input wire [2:0] next_other_bytes,
    output reg dec_valid_r,
    output reg [4:0] op_class_r,
    output reg known_r,
    output reg full_width_r,
    output reg mem_operand_r,
    output reg [2:0] seg_sel_r,
    output reg [2:0] reg_sel_r,
    output reg priv_fault_r,
    output reg [CW-1:0] base_cycles_r,
    output reg [CW-1:0] total_cycles_r,
    output reg [3:0] next_components_r,
    output wire proc_cycle
);
// ---------------------------------------------------------------
// operation classes
// ---------------------------------------------------------------
localparam C_NONE = 5'd0;
localparam C_MOV_SEG = 5'd1;
localparam C_MOV_M2A = 5'd2;
localparam C_MOV_A2M = 5'd3;
localparam C_MOV_IMM = 5'd4;
localparam C_SIGN_EXT = 5'd5;
localparam C_ZERO_EXT = 5'd6;
localparam C_SEG_POP = 5'd7;
localparam C_SEG_PUSH = 5'd8;
localparam C_SWAP = 5'd9;
localparam C_EA_LOAD = 5'd10;
localparam C_FAR_DE = 5'd11;
localparam C_FAR_FG = 5'd12;
localparam C_CARRY_CLR = 5'd13;
localparam C_CARRY_SET = 5'd14;
localparam C_CARRY_INV = 5'd15;
localparam C_DIR_CLR = 5'd16;
localparam C_DIR_SET = 5'd17;
localparam C_INT_CLR = 5'd18;
localparam C_INT_SET = 5'd19;
localparam C_TS_CLR = 5'd20;
localparam C_ACCH_FL = 5'd21;
localparam C_FL_ACCH = 5'd22;
localparam C_MOV_RM = 5'd23;
// ---------------------------------------------------------------
// helpers
// ---------------------------------------------------------------
// mod field of 11 means register operand
function is_mem;
    input [7:0] modrm;
    begin
        is_mem = (modrm[7:6] != 2'b11);
    end
endfunction
// paired count pick: register smaller, memory larger
function [CW-1:0] pair;
    input [CW-1:0] reg_cy;
    input [CW-1:0] mem_cy;
    input m;
    begin
        pair = m ? mem_cy : reg_cy;
    end
endfunction
// mode pick: real/virtual versus protected
function [CW-1:0] mode_pick;
    input [CW-1:0] rl;
    input [CW-1:0] pr;
    input p;
    begin
        mode_pick = p ? pr : rl;
    end
endfunction
// ---------------------------------------------------------------
// combinational decode
// ---------------------------------------------------------------
reg [4:0] cls_nxt;
reg [CW-1:0] cy_nxt;
reg w_nxt;
reg mem_nxt;
reg [2:0] seg_nxt;
reg [2:0] reg_nxt;
reg priv_nxt;
wire esc = (op_byte0 == `OCD_ESC);
wire [7:0] mrm0 = op_byte1;
wire [7:0] mrm1 = op_byte2;
always @*
begin
    cls_nxt = C_NONE;
    cy_nxt = {CW{1'b0}};
    w_nxt = 1'b1;
    mem_nxt = 1'b0;
    seg_nxt = 3'd0;
    reg_nxt = 3'd0;
    priv_nxt = 1'b0;
    // counts below assume the ideal case; extras added after
    if (esc)
    begin
        mem_nxt = is_mem(mrm1);
        reg_nxt = mrm1[5:3];
        if (op_byte1[7:1] == `OCD_X_SIGN_EXT)
        begin
            cls_nxt = C_SIGN_EXT;
            w_nxt = op_byte1[0];
            cy_nxt = pair(`OCD_CY_3, `OCD_CY_6, mem_nxt);
        end
        else if (op_byte1[7:1] == `OCD_X_ZERO_EXT)
        begin
            cls_nxt = C_ZERO_EXT;
            w_nxt = op_byte1[0];
            cy_nxt = pair(`OCD_CY_3, `OCD_CY_6, mem_nxt);
        end
        else if (op_byte1 == `OCD_X_FAR_FSEG ||
                 op_byte1 == `OCD_X_FAR_GSEG)
        begin
            cls_nxt = C_FAR_FG;
            seg_nxt = op_byte1[0] ? 3'd5 : 3'd4;
            cy_nxt = mode_pick(`OCD_CY_7, `OCD_CY_25,
                               protected_mode);
        end
        else if (op_byte1 == `OCD_X_FAR_STACK)
        begin
            cls_nxt = C_FAR_DE;
            seg_nxt = 3'd2;
            cy_nxt = mode_pick(`OCD_CY_7, `OCD_CY_22,
                               protected_mode);
        end
        else if (op_byte1 == `OCD_X_TS_CLR)
        begin
            cls_nxt = C_TS_CLR;
            mem_nxt = 1'b0;
            cy_nxt = `OCD_CY_6;
        end
        else
            mem_nxt = 1'b0;
    end
    else
    begin
        mem_nxt = 1'b0;
        if (op_byte0 == `OCD_MOV_TO_SEG)
        begin
            cls_nxt = C_MOV_SEG;
            mem_nxt = is_mem(mrm0);
            seg_nxt = mrm0[5:3];
            cy_nxt = protected_mode ?
                pair(`OCD_CY_18, `OCD_CY_19, mem_nxt) :
                pair(`OCD_CY_2, `OCD_CY_5, mem_nxt);
        end
        else if (op_byte0[7:1] == `OCD_MOV_M2A)
        begin
            cls_nxt = C_MOV_M2A;
            mem_nxt = 1'b1;
            w_nxt = op_byte0[0];
            cy_nxt = `OCD_CY_4;
        end
        else if (op_byte0[7:1] == `OCD_MOV_A2M)
        begin
            cls_nxt = C_MOV_A2M;
            mem_nxt = 1'b1;
            w_nxt = op_byte0[0];
            cy_nxt = `OCD_CY_2;
        end
        else if (op_byte0[7:4] == `OCD_MOV_IMM_R)
        begin
            cls_nxt = C_MOV_IMM;
            w_nxt = op_byte0[3];
            reg_nxt = op_byte0[2:0];
            cy_nxt = `OCD_CY_2;
        end
        else if (op_byte0[7:5] == 3'b000 &&
                 op_byte0[2:0] == `OCD_SEG_POP_LO &&
                 op_byte0[4:3] != 2'b01)
        begin
            cls_nxt = C_SEG_POP;
            seg_nxt = {1'b0, op_byte0[4:3]};
            cy_nxt = mode_pick(`OCD_CY_7, `OCD_CY_21,
                               protected_mode);
        end
        else if (op_byte0[7:5] == 3'b000 &&
                 op_byte0[2:0] == `OCD_SEG_PUSH_LO)
        begin
            cls_nxt = C_SEG_PUSH;
            seg_nxt = {1'b0, op_byte0[4:3]};
            cy_nxt = `OCD_CY_2;
        end
        else if (op_byte0[7:3] == `OCD_SWAP_ACC)
        begin
            cls_nxt = C_SWAP;
            reg_nxt = op_byte0[2:0];
            cy_nxt = `OCD_CY_3;
        end
        else if (op_byte0 == `OCD_EA_LOAD)
        begin
            cls_nxt = C_EA_LOAD;
            reg_nxt = mrm0[5:3];
            cy_nxt = `OCD_CY_2;
        end
        else if (op_byte0 == `OCD_FAR_DSEG || op_byte0 == `OCD_FAR_ESEG)
        begin
            cls_nxt = C_FAR_DE;
            mem_nxt = is_mem(mrm0);
            reg_nxt = mrm0[5:3];
            seg_nxt = op_byte0[0] ? 3'd3 : 3'd0;
            cy_nxt = mode_pick(`OCD_CY_7, `OCD_CY_22,
                               protected_mode);
        end
        else if (op_byte0[7:1] == `OCD_MOV_R_RM)
        begin
            cls_nxt = C_MOV_RM;
            mem_nxt = is_mem(mrm0);
            w_nxt = op_byte0[0];
            reg_nxt = mrm0[5:3];
            cy_nxt = pair(`OCD_CY_2, `OCD_CY_4, mem_nxt);
        end
        else
        begin
            case (op_byte0)
                `OCD_CARRY_CLR:
                begin
                    cls_nxt = C_CARRY_CLR;
                    cy_nxt = `OCD_CY_2;
                end
                `OCD_CARRY_SET:
                begin
                    cls_nxt = C_CARRY_SET;
                    cy_nxt = `OCD_CY_2;
                end
                `OCD_CARRY_INV:
                begin
                    cls_nxt = C_CARRY_INV;
                    cy_nxt = `OCD_CY_2;
                end
                `OCD_DIR_CLR:
                begin
                    cls_nxt = C_DIR_CLR;
                    cy_nxt = `OCD_CY_2;
                end
                `OCD_DIR_SET:
                begin
                    cls_nxt = C_DIR_SET;
                    cy_nxt = `OCD_CY_2;
                end
                `OCD_INT_CLR, `OCD_INT_SET:
                begin
                    cls_nxt = op_byte0[0] ? C_INT_SET : C_INT_CLR;
                    cy_nxt = `OCD_CY_8;
                    priv_nxt = protected_mode & ~io_priv_ok;
                end
                `OCD_ACCH_TO_FL:
                begin
                    cls_nxt = C_ACCH_FL;
                    cy_nxt = `OCD_CY_3;
                end
                `OCD_FL_TO_ACCH:
                begin
                    cls_nxt = C_FL_ACCH;
                    cy_nxt = `OCD_CY_2;
                end
                default:
                begin
                    cls_nxt = C_NONE;
                end
            endcase
        end
    end
end
// ---------------------------------------------------------------
// adjustments and cycle strobe
// ---------------------------------------------------------------
wire [CW-1:0] total_nxt;
ocd_adjust #(.CW(CW)) u_adj
(
    .base_cycles(cy_nxt),
    .ea_two_regs(ea_two_regs),
    .uses_mem(mem_nxt),
    .wait_states(wait_states),
    .data_accesses(data_accesses),
    .total_cycles(total_nxt)
);
ocd_clk_half u_clk
(
    .clk_sys(clk_sys),
    .srst(srst),
    .double_rate_clock_in(double_rate_clock_in),
    .proc_cycle_r(proc_cycle)
);
// displacement whole = one, immediate whole = one, others each one
wire [3:0] comp_nxt = {3'd0, |next_disp_present} +
    {3'd0, next_imm_present} + {1'b0, next_other_bytes};
// ---------------------------------------------------------------
// output registers
// ---------------------------------------------------------------
always @(posedge clk_sys)
begin
    if (srst)
    begin
        dec_valid_r <= 1'b0;
        op_class_r <= C_NONE;
        known_r <= 1'b0;
        full_width_r <= 1'b0;
        mem_operand_r <= 1'b0;
        seg_sel_r <= 3'd0;
        reg_sel_r <= 3'd0;
        priv_fault_r <= 1'b0;
        base_cycles_r <= {CW{1'b0}};
        total_cycles_r <= {CW{1'b0}};
        next_components_r <= 4'd0;
    end
    else
    begin
        dec_valid_r <= instr_valid;
        if (instr_valid)
        begin
            op_class_r <= cls_nxt;
            known_r <= (cls_nxt != C_NONE);
            full_width_r <= w_nxt;
            mem_operand_r <= mem_nxt;
            seg_sel_r <= seg_nxt;
            reg_sel_r <= reg_nxt;
            priv_fault_r <= priv_nxt;
            base_cycles_r <= cy_nxt;
            total_cycles_r <= total_nxt;
            next_components_r <= comp_nxt;
        end
    end
end
endmodule // ocd_decode

// [sim/ocd_decode_monitor.sv]
// assertion checker for the opcode decoder ports
`timescale 1ns/1ps
module ocd_decode_monitor
#(
    parameter CW = 8
)
(
    input wire clk_sys,
    input wire srst,
    input wire instr_valid,
    input wire [7:0] op_byte0,
    input wire [7:0] op_byte1,
    input wire protected_mode,
    input wire io_priv_ok,
    input wire ea_two_regs,
    input wire [3:0] wait_states,
    input wire [2:0] data_accesses,
    input wire [2:0] next_disp_present,
    input wire next_imm_present,
    input wire [2:0] next_other_bytes,
    input wire dec_valid_r,
    input wire known_r,
    input wire mem_operand_r,
    input wire priv_fault_r,
    input wire [CW-1:0] base_cycles_r,
    input wire [CW-1:0] total_cycles_r,
    input wire [3:0] next_components_r,
    input wire proc_cycle
);
    wire mod_reg = (op_byte1[7:6] == 2'h3);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (srst);
    sequence s_take;
        instr_valid ##1 dec_valid_r;
    endsequence
    sequence s_int_req;
        instr_valid && (op_byte0 == 8'hfa || op_byte0 == 8'hfb);
    endsequence
    chk_valid_follows:
    assert property (instr_valid |-> s_take)
        else $error("decode result not flagged one cycle after request");
    chk_valid_pulse:
    assert property (!instr_valid |=> !dec_valid_r)
        else $error("result flag without a request");
    chk_result_hold:
    assert property (!instr_valid |=> $stable(total_cycles_r) && $stable(known_r))
        else $error("results changed without a request");
    chk_wait_extra:
    assert property (instr_valid && !ea_two_regs |=> total_cycles_r ==
        base_cycles_r + $past(wait_states) * $past(data_accesses))
        else $error("wait state extra wrong");
    chk_ea_extra:
    assert property (instr_valid && ea_two_regs |=> total_cycles_r ==
        base_cycles_r + mem_operand_r + $past(wait_states) * $past(data_accesses))
        else $error("two register address extra wrong");
    chk_seg_move_cy:
    assert property (instr_valid && op_byte0 == 8'h8e |=> base_cycles_r ==
        ($past(protected_mode) ? ($past(mod_reg) ? 8'h12 : 8'h13)
        : ($past(mod_reg) ? 8'h02 : 8'h05)))
        else $error("segment move count wrong");
    chk_far_ptr_cy:
    assert property (instr_valid && op_byte0[7:1] == 7'h62 |=> base_cycles_r ==
        ($past(protected_mode) ? 8'h16 : 8'h07))
        else $error("far pointer count wrong");
    chk_flag_cy:
    assert property (instr_valid && (op_byte0 == 8'hf8 || op_byte0 == 8'hf9 ||
        op_byte0 == 8'hf5 || op_byte0[7:1] == 7'h7e) |=> base_cycles_r == 8'h02)
        else $error("flag op count wrong");
    chk_int_cy:
    assert property (s_int_req |=> base_cycles_r == 8'h08)
        else $error("interrupt enable op count wrong");
    chk_priv_fault:
    assert property (s_int_req |=> priv_fault_r ==
        ($past(protected_mode) && !$past(io_priv_ok)))
        else $error("privilege fault wrong");
    chk_next_count:
    assert property (instr_valid |=> next_components_r ==
        ($past(next_disp_present) != 3'h0) + $past(next_imm_present)
        + $past(next_other_bytes))
        else $error("next component count wrong");
    chk_proc_pulse:
    assert property (proc_cycle |=> !proc_cycle [*3])
        else $error("processor cycle strobe too long or too fast");
endmodule // ocd_decode_monitor

bind ocd_decode ocd_decode_monitor #(.CW(CW)) i_mon (.clk_sys(clk_sys),
    .srst(srst), .instr_valid(instr_valid), .op_byte0(op_byte0),
    .op_byte1(op_byte1), .protected_mode(protected_mode),
    .io_priv_ok(io_priv_ok), .ea_two_regs(ea_two_regs),
    .wait_states(wait_states), .data_accesses(data_accesses),
    .next_disp_present(next_disp_present),
    .next_imm_present(next_imm_present), .next_other_bytes(next_other_bytes),
    .dec_valid_r(dec_valid_r), .known_r(known_r),
    .mem_operand_r(mem_operand_r), .priv_fault_r(priv_fault_r),
    .base_cycles_r(base_cycles_r), .total_cycles_r(total_cycles_r),
    .next_components_r(next_components_r), .proc_cycle(proc_cycle));

// [sim/ocd_decode_tb.sv]
// self-checking bench for the opcode decoder
`timescale 1ns/1ps
module ocd_decode_tb;
    // ---------------------------------------------------------------
    // signals
    // ---------------------------------------------------------------
    localparam [8*26-1:0] T0 = {8'h8e, 8'ha0, 8'ha2, 8'hb0, 8'h0f, 8'h0f,
        8'h07, 8'h06, 8'h90, 8'h8d, 8'hc5, 8'hc4, 8'h0f, 8'h0f, 8'h0f, 8'hf8,
        8'hf9, 8'hf5, 8'hfc, 8'hfd, 8'hfa, 8'hfb, 8'h0f, 8'h9e, 8'h9f, 8'h27};
    localparam [8*26-1:0] T1 = {8'h00, 8'h00, 8'h00, 8'h00, 8'hbe, 8'hb6,
        48'h0, 8'hb4, 8'hb5, 8'hb2, 56'h0, 8'h06, 24'h0};
    reg clk_sys = 1'b0;
    reg srst = 1'b1;
    reg double_rate_clock_in = 1'b0;
    reg instr_valid = 1'b0;
    reg [7:0] op_byte0 = 8'h00;
    reg [7:0] op_byte1 = 8'h00;
    reg [7:0] op_byte2 = 8'h00;
    reg protected_mode = 1'b0;
    reg io_priv_ok = 1'b0;
    reg ea_two_regs = 1'b0;
    reg [3:0] wait_states = 4'h0;
    reg [2:0] data_accesses = 3'h0;
    reg [2:0] next_disp_present = 3'h0;
    reg next_imm_present = 1'b0;
    reg [2:0] next_other_bytes = 3'h0;
    wire dec_valid_r, known_r, full_width_r, mem_operand_r, priv_fault_r;
    wire proc_cycle;
    wire [4:0] op_class_r;
    wire [2:0] seg_sel_r, reg_sel_r;
    wire [7:0] base_cycles_r, total_cycles_r;
    wire [3:0] next_components_r;
    integer seed = 32'h532406c2;
    integer n_errors = 0;
    integer num_checks = 0;
    integer i, j, pc_cnt = 0;
    reg pc_en = 1'b0;
    reg [7:0] b0, b1, b2, e_base;
    reg e_known, e_full, e_mem, e_pair, e_eam;
    reg [2:0] e_seg, e_reg;
    reg e_sck, e_rck;

    ocd_decode #(.CW(8)) i_dut (.clk_sys(clk_sys), .srst(srst),
        .double_rate_clock_in(double_rate_clock_in),
        .instr_valid(instr_valid), .op_byte0(op_byte0), .op_byte1(op_byte1),
        .op_byte2(op_byte2), .protected_mode(protected_mode),
        .io_priv_ok(io_priv_ok), .ea_two_regs(ea_two_regs),
        .wait_states(wait_states), .data_accesses(data_accesses),
        .next_disp_present(next_disp_present),
        .next_imm_present(next_imm_present),
        .next_other_bytes(next_other_bytes), .dec_valid_r(dec_valid_r),
        .op_class_r(op_class_r), .known_r(known_r),
        .full_width_r(full_width_r), .mem_operand_r(mem_operand_r),
        .seg_sel_r(seg_sel_r), .reg_sel_r(reg_sel_r),
        .priv_fault_r(priv_fault_r), .base_cycles_r(base_cycles_r),
        .total_cycles_r(total_cycles_r),
        .next_components_r(next_components_r), .proc_cycle(proc_cycle));

    always #2.5 clk_sys = ~clk_sys;
    always #15 double_rate_clock_in = ~double_rate_clock_in;
    always @(posedge clk_sys)
        if (pc_en && proc_cycle === 1'b1)
            pc_cnt <= pc_cnt + 1;
    // ---------------------------------------------------------------
    // expectation model and compares
    // ---------------------------------------------------------------
    function automatic void model(input [7:0] c0, c1, c2, input pm);
        reg [7:0] m;
        m = (c0 == 8'h0f) ? c2 : c1;
        e_mem = (m[7:6] != 2'h3);
        {e_known, e_full, e_pair, e_eam, e_sck, e_rck} = 6'b110000;
        e_base = 8'h02;
        e_seg = 3'h0;
        e_reg = c0[2:0];
        if (c0 == 8'h8e)
            {e_pair, e_sck, e_seg, e_base} = {2'b11, m[5:3],
                pm ? (e_mem ? 8'h13 : 8'h12) : (e_mem ? 8'h05 : 8'h02)};
        else if (c0[7:2] == 6'h28)
            {e_eam, e_full, e_base} = {1'b1, c0[0], c0[1] ? 8'h02 : 8'h04};
        else if (c0[7:4] == 4'hb)
            {e_full, e_rck} = {c0[3], 1'b1};
        else if (c0 == 8'h0f && (c1[7:1] == 7'h5f || c1[7:1] == 7'h5b))
            {e_pair, e_full, e_base} = {1'b1, c1[0], e_mem ? 8'h06 : 8'h03};
        else if (c0[7:5] == 3'h0 && c0[2:1] == 2'h3 && c0 != 8'h0f)
            {e_sck, e_seg, e_base} = {2'b10, c0[4:3],
                c0[0] ? (pm ? 8'h15 : 8'h07) : 8'h02};
        else if (c0[7:3] == 5'h12)
            {e_rck, e_base} = {1'b1, 8'h03};
        else if (c0[7:1] == 7'h62 || (c0 == 8'h0f && c1 == 8'hb2))
            {e_sck, e_seg, e_base} = {1'b1, c0 == 8'hc4 ? 3'h0 :
                c0 == 8'hc5 ? 3'h3 : 3'h2, pm ? 8'h16 : 8'h07};
        else if (c0 == 8'h0f && c1[7:1] == 7'h5a)
            {e_sck, e_seg, e_base} = {1'b1, 2'h2, c1[0], pm ? 8'h19 : 8'h07};
        else if (c0[7:1] == 7'h45)
            {e_pair, e_rck, e_reg, e_full, e_base} = {2'b11, m[5:3], c0[0],
                e_mem ? 8'h04 : 8'h02};
        else if (c0 == 8'hfa || c0 == 8'hfb)
            e_base = 8'h08;
        else if (c0 == 8'h0f && c1 == 8'h06)
            e_base = 8'h06;
        else if (c0 == 8'h9e)
            e_base = 8'h03;
        else if (!(c0 inside {8'hf8, 8'hf9, 8'hf5, 8'hfc, 8'hfd, 8'h9f,
            8'h8d}))
            {e_known, e_base} = 9'h0;
    endfunction

    task automatic cmp(input string nm, input [7:0] e, input [7:0] g);
        begin
            num_checks = num_checks + 1;
            if (g !== e)
            begin
                n_errors = n_errors + 1;
                $display("[ERR] %s expected %h seen %h", nm, e, g);
            end
        end
    endtask

    task automatic go(input pm, iop, ea, input [3:0] ws, input [2:0] na);
        reg [2:0] nd, no;
        reg ni;
        begin
            nd = $random(seed);
            no = $random(seed);
            ni = $random(seed);
            @(posedge clk_sys);
            {op_byte0, op_byte1, op_byte2} <= {b0, b1, b2};
            {protected_mode, io_priv_ok, ea_two_regs} <= {pm, iop, ea};
            {wait_states, data_accesses, instr_valid} <= {ws, na, 1'b1};
            {next_disp_present, next_imm_present} <= {nd, ni};
            next_other_bytes <= no;
            model(b0, b1, b2, pm);
            @(posedge clk_sys);
            #1;
            cmp("valid", 8'h1, dec_valid_r);
            cmp("known", e_known, known_r);
            cmp("class", e_known, |op_class_r);
            cmp("base", e_base, base_cycles_r);
            if (e_known)
                cmp("total", e_base + (e_eam | e_pair & e_mem) * ea
                    + ws * na, total_cycles_r);
            cmp("width", e_full, full_width_r);
            if (e_pair)
                cmp("mem", e_mem, mem_operand_r);
            if (e_sck)
                cmp("seg", e_seg, seg_sel_r);
            if (e_rck)
                cmp("reg", e_reg, reg_sel_r);
            cmp("priv", b0[7:1] == 7'h7d && pm && !iop,
                priv_fault_r);
            cmp("next", (nd != 0) + ni + no, next_components_r);
        end
    endtask

    task automatic pick(input integer k);
        reg [7:0] r;
        integer p;
        begin
            r = $random(seed);
            // first table entry sits in the top byte
            p = 8 * (25 - k);
            b0 = T0[p +: 8];
            b1 = $random(seed);
            b2 = $random(seed);
            if (b0 == 8'h0f)
                b1 = T1[p +: 8] | (T1[p+7] & T1[p+2] & T1[p+1] & r[0]);
            if (b0[7:2] == 6'h28)
                b0[0] = r[0];
            if (b0 == 8'hb0 || b0 == 8'h90)
                b0[3:0] = r[3:0] & {b0[5], 3'h7};
            if (b0 == 8'h06)
                b0[4:3] = r[4:3];
            if (b0 == 8'h07)
                b0[4:3] = r[4] ? 2'h3 : {r[3], 1'b0};
        end
    endtask

    task conclude;
        begin
            $display("checks %0d errors %0d", num_checks, n_errors);
            if (n_errors == 0 && num_checks > 0)
                $display("ALL TESTS PASSED");
            else
                $display("TESTS FAILED");
            $finish;
        end
    endtask
    // ---------------------------------------------------------------
    // sequence
    // ---------------------------------------------------------------
    initial
    begin
        #50000;
        n_errors = n_errors + 1;
        conclude;
    end

    initial
    begin
        repeat (10) @(posedge clk_sys);
        srst <= 1'b0;
        for (i = 0; i < 26; i = i + 1)
            for (j = 0; j < 4; j = j + 1)
            begin
                pick(i);
                go(j[0], j[1], i < 6, 4'hf, 3'h7);
            end
        b2 = 8'h00;
        for (j = 0; j < 8; j = j + 1)
        begin
            b0 = j[2] ? 8'h8b : 8'h8e;
            b1 = j[1] ? 8'hc5 : 8'h05;
            go(j[0], 1'b1, 1'b1, 4'h0, 3'h0);
        end
        for (i = 0; i < 300; i = i + 1)
        begin
            j = {$random(seed)} % 26;
            pick(j);
            go($random(seed), $random(seed), (j < 6) & $random(seed),
                $random(seed), $random(seed));
            if (i % 5 == 0)
            begin
                @(posedge clk_sys);
                instr_valid <= 1'b0;
                @(posedge clk_sys);
                #1;
                cmp("idle", 8'h0, dec_valid_r);
            end
        end
        pc_en = 1'b1;
        repeat (240) @(posedge clk_sys);
        pc_en = 1'b0;
        cmp("strobes", 8'h1, pc_cnt >= 19 && pc_cnt <= 21);
        conclude;
    end
endmodule // ocd_decode_tb
